//--- core/spicc_pkg.sv
// Register map, field positions and reset values of the serial port control block.
// Assumes a 32-bit Avalon-MM slave with one aligned word per register.
// Function
// - Whole main control register is ignored while the port runs in audio mode.
// - Line mode bit 15: zero two-line unidirectional, one single-line bidirectional.
// - Single-line mode: direction bit 14 zero receives only, one transmits only.
// - Checksum is computed only while checksum enable bit 13 is set.
// - Checksum-next bit 12 makes next transfer the checksum; DMA sends it itself.
// - Frame width bit 11: zero shifts 8-bit frames, one shifts 16-bit frames.
// - Two-line mode: receive-only bit 10 zero full-duplex, one receive only.
// - Select enable bit 9 picks pin or soft level; ignored in frame-format mode.
// - Soft select level bit 8 acts only with soft select, outside frame-format mode.
// - Bit order bit 7: zero MSB first, one LSB first; ignored in frame-format.
// - Port enable bit 6 zero keeps port disabled, one operates it.
// - Divider field bits 5:3 divides bus clock by 2 to 128; code 7 gives 128.
// - First port instance uses the second bus clock, others the first one.
// - Master select bit 2: zero slave, one master.
// - Idle clock level bit 1: zero idles low, one idles high.
// - Capture bit 0: first data on first transition if zero, second if one.
// - Interrupt while tx-empty enable and flag, or rx-full enable and flag.
// - Fault enable raises interrupt when any checksum, config, overrun, underrun flag sets.
// - Frame-format enable bit 4 selects synchronous frame-format variant.
// - Select pulse bit 3 enables chip-select pulse mode.
// - Chip-select pin is driven only while select output enable bit is set.
// - DMA enables request transfers on tx-empty or rx-not-empty.
package spicc_pkg;
  localparam logic [7:0] MAIN_OFS = 8'h00;
  localparam logic [7:0] AUX_OFS = 8'h04;
  localparam logic [7:0] STATE_OFS = 8'h08;
  localparam logic [15:0] MAIN_RESET = 16'h0000;
  localparam logic [7:0] AUX_RESET = 8'h00;
  // Main control fields
  localparam int ONE_LINE_MODE = 15;
  localparam int ONE_LINE_DIRECTION = 14;
  localparam int CHECKSUM_ENABLE = 13;
  localparam int CHECKSUM_NEXT = 12;
  localparam int FRAME_WIDTH_SEL = 11;
  localparam int RECEIVE_ONLY_SEL = 10;
  localparam int SOFT_SELECT_ENABLE = 9;
  localparam int SOFT_SELECT_LEVEL = 8;
  localparam int BIT_ORDER_SEL = 7;
  localparam int PORT_ENABLE = 6;
  localparam int DIVIDER_LSB = 3;
  localparam int MASTER_SELECT = 2;
  localparam int IDLE_CLOCK_LEVEL = 1;
  localparam int CAPTURE_EDGE_SEL = 0;
  // Auxiliary control fields
  localparam int TX_EMPTY_IRQ_ENABLE = 7;
  localparam int RX_FULL_IRQ_ENABLE = 6;
  localparam int FAULT_IRQ_ENABLE = 5;
  localparam int FRAME_FORMAT_MODE_ENABLE = 4;
  localparam int SELECT_PULSE_ENABLE = 3;
  localparam int SELECT_OUTPUT_ENABLE = 2;
  localparam int TX_DMA_ENABLE = 1;
  localparam int RX_DMA_ENABLE = 0;
  // Live state word fields
  localparam int ST_PIN_LEVEL = 0;
  localparam int ST_SELECT_LEVEL = 1;
  localparam int ST_CLOCK_RUN = 2;
  localparam int ST_IRQ = 3;
  localparam logic [2:0] DIVIDER_MAX_CODE = 3'h6;
endpackage : spicc_pkg

//--- core/spicc_top.sv
// Serial port control block: control registers, decoded modes, bit clock divider,
// chip-select source, interrupt and DMA request gating.
// Assumes the shifter shares i_mclk; only the chip-select pin is asynchronous.
`timescale 1ns/1ps
module spicc_top #(
  parameter int PORT_INDEX = 0
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_audio_mode,
  input wire logic i_first_bus_tick,
  input wire logic i_second_bus_tick,
  input wire logic i_shift_busy,
  input wire logic i_chip_select_pin,
  input wire logic i_tx_empty_flag,
  input wire logic i_rx_full_flag,
  input wire logic i_checksum_fault_flag,
  input wire logic i_config_fault_flag,
  input wire logic i_rx_overrun_flag,
  input wire logic i_tx_underrun_flag,
  output logic o_one_line_mode,
  output logic o_tx_active,
  output logic o_rx_active,
  output logic o_checksum_enable,
  output logic o_checksum_next,
  output logic o_frame_16,
  output logic o_lsb_first,
  output logic o_port_enable,
  output logic o_master,
  output logic o_capture_second,
  output logic o_serial_clk,
  output logic o_select_level,
  output logic o_chip_select_out,
  output logic o_chip_select_oe,
  output logic o_select_pulse,
  output logic o_frame_format,
  output logic o_irq,
  output logic o_tx_dma_req,
  output logic o_rx_dma_req
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Half period of the bit clock in bus ticks; code 7 repeats the code 6 divisor
  function automatic logic [6:0] half_ticks(input logic [2:0] code);
    logic [2:0] c;
    c = (code > spicc_pkg::DIVIDER_MAX_CODE) ? spicc_pkg::DIVIDER_MAX_CODE : code;
    half_ticks = 7'(7'h01 << c);
  endfunction : half_ticks

  logic [15:0] main_ctl;
  logic [7:0] aux_ctl;
  logic [15:0] eff_main;
  logic sel_s1;
  logic sel_s2;
  logic sel_s3;
  logic pin_level;
  logic bus_tick;
  logic clock_run;
  logic [6:0] tick_cnt;
  logic next_irq;
  logic [31:0] next_readdata;
  logic wr_take;
  logic [15:0] wmask;

  // Audio mode hides the whole main control word
  assign eff_main = i_audio_mode ? spicc_pkg::MAIN_RESET : main_ctl;
  // Prescaler source depends on which port instance this is
  assign bus_tick = (PORT_INDEX == 0) ? i_second_bus_tick : i_first_bus_tick;
  assign wr_take = i_write && !o_waitrequest;
  assign wmask = {{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then the answer

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_waitrequest <= 1'b1;
    end else begin
      o_waitrequest <= !((i_read || i_write) && o_waitrequest);
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    case (i_address)
      spicc_pkg::MAIN_OFS: next_readdata = {16'h0000, main_ctl};
      spicc_pkg::AUX_OFS: next_readdata = {24'h00_0000, aux_ctl};
      spicc_pkg::STATE_OFS: begin
        next_readdata[spicc_pkg::ST_PIN_LEVEL] = pin_level;
        next_readdata[spicc_pkg::ST_SELECT_LEVEL] = o_select_level;
        next_readdata[spicc_pkg::ST_CLOCK_RUN] = clock_run;
        next_readdata[spicc_pkg::ST_IRQ] = o_irq;
      end
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_readdata <= 32'h0000_0000;
    end else if (i_read && o_waitrequest) begin
      o_readdata <= next_readdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      main_ctl <= spicc_pkg::MAIN_RESET;
    end else if (wr_take && i_address == spicc_pkg::MAIN_OFS) begin
      main_ctl <= (main_ctl & ~wmask) | (i_writedata[15:0] & wmask);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      aux_ctl <= spicc_pkg::AUX_RESET;
    end else if (wr_take && i_address == spicc_pkg::AUX_OFS && i_byteenable[0]) begin
      aux_ctl <= i_writedata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Chip-select pin: three stages, a change counts once stages two and three agree

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      sel_s3 <= 1'b1;
      pin_level <= 1'b1;
    end else begin
      sel_s1 <= i_chip_select_pin;
      sel_s2 <= sel_s1;
      sel_s3 <= sel_s2;
      if (sel_s2 == sel_s3) begin
        pin_level <= sel_s3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded modes

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_one_line_mode <= 1'b0;
      o_tx_active <= 1'b0;
      o_rx_active <= 1'b0;
    end else begin
      o_one_line_mode <= eff_main[spicc_pkg::ONE_LINE_MODE];
      if (eff_main[spicc_pkg::ONE_LINE_MODE]) begin
        // Single line carries one direction at a time
        o_tx_active <= eff_main[spicc_pkg::ONE_LINE_DIRECTION];
        o_rx_active <= !eff_main[spicc_pkg::ONE_LINE_DIRECTION];
      end else begin
        o_tx_active <= !eff_main[spicc_pkg::RECEIVE_ONLY_SEL];
        o_rx_active <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_checksum_enable <= 1'b0;
      o_checksum_next <= 1'b0;
    end else begin
      o_checksum_enable <= eff_main[spicc_pkg::CHECKSUM_ENABLE];
      // With transmit DMA the shifter appends the checksum itself, so the bit is masked
      o_checksum_next <= eff_main[spicc_pkg::CHECKSUM_ENABLE]
        && eff_main[spicc_pkg::CHECKSUM_NEXT]
        && !aux_ctl[spicc_pkg::TX_DMA_ENABLE];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_frame_16 <= 1'b0;
      o_lsb_first <= 1'b0;
      o_port_enable <= 1'b0;
      o_master <= 1'b0;
      o_capture_second <= 1'b0;
      o_frame_format <= 1'b0;
      o_select_pulse <= 1'b0;
    end else begin
      o_frame_16 <= eff_main[spicc_pkg::FRAME_WIDTH_SEL];
      // Frame-format variant is always MSB first
      o_lsb_first <= eff_main[spicc_pkg::BIT_ORDER_SEL]
        && !aux_ctl[spicc_pkg::FRAME_FORMAT_MODE_ENABLE];
      o_port_enable <= eff_main[spicc_pkg::PORT_ENABLE];
      o_master <= eff_main[spicc_pkg::MASTER_SELECT];
      o_capture_second <= eff_main[spicc_pkg::CAPTURE_EDGE_SEL];
      o_frame_format <= aux_ctl[spicc_pkg::FRAME_FORMAT_MODE_ENABLE];
      o_select_pulse <= aux_ctl[spicc_pkg::SELECT_PULSE_ENABLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Chip-select source and pin drive

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_select_level <= 1'b1;
    end else if (aux_ctl[spicc_pkg::FRAME_FORMAT_MODE_ENABLE]) begin
      o_select_level <= pin_level;
    end else if (eff_main[spicc_pkg::SOFT_SELECT_ENABLE]) begin
      o_select_level <= eff_main[spicc_pkg::SOFT_SELECT_LEVEL];
    end else begin
      o_select_level <= pin_level;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_chip_select_oe <= 1'b0;
      o_chip_select_out <= 1'b1;
    end else begin
      o_chip_select_oe <= aux_ctl[spicc_pkg::SELECT_OUTPUT_ENABLE];
      // Select is asserted low while an enabled master owns the bus
      o_chip_select_out <= !(eff_main[spicc_pkg::MASTER_SELECT]
        && eff_main[spicc_pkg::PORT_ENABLE]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Master bit clock: toggles every half period counted in bus ticks

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      clock_run <= 1'b0;
    end else begin
      clock_run <= eff_main[spicc_pkg::MASTER_SELECT] && eff_main[spicc_pkg::PORT_ENABLE]
        && i_shift_busy;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tick_cnt <= 7'h00;
      o_serial_clk <= 1'b0;
    end else if (!clock_run) begin
      // Idle level is reapplied whenever the clock stops, so a polarity change is safe
      tick_cnt <= 7'h00;
      o_serial_clk <= eff_main[spicc_pkg::IDLE_CLOCK_LEVEL];
    end else if (bus_tick) begin
      if (tick_cnt + 7'h01 >= half_ticks(eff_main[spicc_pkg::DIVIDER_LSB +: 3])) begin
        tick_cnt <= 7'h00;
        o_serial_clk <= !o_serial_clk;
      end else begin
        tick_cnt <= 7'(tick_cnt + 7'h01);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt and DMA requests

  always_comb begin
    next_irq = (aux_ctl[spicc_pkg::TX_EMPTY_IRQ_ENABLE] && i_tx_empty_flag)
      || (aux_ctl[spicc_pkg::RX_FULL_IRQ_ENABLE] && i_rx_full_flag);
    if (aux_ctl[spicc_pkg::FAULT_IRQ_ENABLE] && (i_checksum_fault_flag
        || i_config_fault_flag || i_rx_overrun_flag || i_tx_underrun_flag)) begin
      next_irq = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_irq <= 1'b0;
      o_tx_dma_req <= 1'b0;
      o_rx_dma_req <= 1'b0;
    end else begin
      o_irq <= next_irq;
      o_tx_dma_req <= aux_ctl[spicc_pkg::TX_DMA_ENABLE] && i_tx_empty_flag;
      o_rx_dma_req <= aux_ctl[spicc_pkg::RX_DMA_ENABLE] && i_rx_full_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  sequence bus_write_main_s;
    i_write && o_waitrequest && i_address == spicc_pkg::MAIN_OFS;
  endsequence

  sequence write_done_s;
    !o_waitrequest;
  endsequence

  sequence tx_empty_armed_s;
    aux_ctl[spicc_pkg::TX_EMPTY_IRQ_ENABLE] && i_tx_empty_flag;
  endsequence

  audio_hides_main_a: assert property (i_audio_mode ##1 i_audio_mode |=>
    !o_port_enable && !o_master && !o_frame_16)
    else $error("Main control not hidden in audio mode");

  one_line_dir_a: assert property (o_one_line_mode |-> o_tx_active != o_rx_active)
    else $error("Single line mode drives both directions");

  // Outputs still hold reset values on the first edge after release
  two_line_rx_a: assert property (!$past(i_srst)
    && $past(!eff_main[spicc_pkg::ONE_LINE_MODE])
    |-> o_rx_active && o_tx_active == $past(!eff_main[spicc_pkg::RECEIVE_ONLY_SEL]))
    else $error("Two-line direction wrong");

  next_needs_crc_a: assert property (o_checksum_next |->
    $past(eff_main[spicc_pkg::CHECKSUM_ENABLE]) && !$past(aux_ctl[spicc_pkg::TX_DMA_ENABLE]))
    else $error("Checksum next without enable or under DMA");

  write_lands_a: assert property (bus_write_main_s ##1 write_done_s |=>
    main_ctl[spicc_pkg::PORT_ENABLE] == $past(i_writedata[spicc_pkg::PORT_ENABLE])
    || !$past(i_byteenable[0]))
    else $error("Main control write lost");

  wait_one_cycle_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("Slave did not answer after one wait cycle");

  soft_select_a: assert property (!aux_ctl[spicc_pkg::FRAME_FORMAT_MODE_ENABLE]
    && eff_main[spicc_pkg::SOFT_SELECT_ENABLE] |=> o_select_level
    == $past(eff_main[spicc_pkg::SOFT_SELECT_LEVEL]))
    else $error("Soft select level not applied");

  lsb_frame_a: assert property (o_lsb_first |-> !o_frame_format)
    else $error("Bit order not forced in frame-format mode");

  idle_clock_a: assert property (!clock_run ##1 !clock_run |->
    o_serial_clk == $past(eff_main[spicc_pkg::IDLE_CLOCK_LEVEL]))
    else $error("Bit clock not at idle level");

  tick_range_a: assert property (
    tick_cnt < half_ticks(eff_main[spicc_pkg::DIVIDER_LSB +: 3]) || $changed(eff_main))
    else $error("Divider count out of range");

  fault_irq_a: assert property (
    aux_ctl[spicc_pkg::FAULT_IRQ_ENABLE] && i_rx_overrun_flag |=> o_irq)
    else $error("Fault interrupt missing");

  dma_req_a: assert property (o_tx_dma_req |-> $past(i_tx_empty_flag))
    else $error("Transmit DMA request without empty buffer");

  one_line_mode_a: assert property (!$past(i_srst) |->
    o_one_line_mode == $past(eff_main[spicc_pkg::ONE_LINE_MODE]))
    else $error("Line mode not decoded");

  frame_width_a: assert property (!$past(i_srst) |->
    o_frame_16 == $past(eff_main[spicc_pkg::FRAME_WIDTH_SEL]))
    else $error("Frame width not decoded");

  checksum_off_a: assert property ($past(!eff_main[spicc_pkg::CHECKSUM_ENABLE]) |->
    !o_checksum_enable && !o_checksum_next)
    else $error("Checksum active while disabled");

  // A slave or a disabled port must never run the bit clock
  clock_gate_a: assert property ($past(!eff_main[spicc_pkg::MASTER_SELECT]
    || !eff_main[spicc_pkg::PORT_ENABLE]) |-> !clock_run)
    else $error("Bit clock runs outside an enabled master");

  frame_select_a: assert property (aux_ctl[spicc_pkg::FRAME_FORMAT_MODE_ENABLE] |=>
    o_select_level == $past(pin_level))
    else $error("Frame-format select not taken from pin");

  select_oe_a: assert property (!$past(i_srst) |->
    o_chip_select_oe == $past(aux_ctl[spicc_pkg::SELECT_OUTPUT_ENABLE]))
    else $error("Select output enable not applied");

  tx_irq_a: assert property (tx_empty_armed_s |=> o_irq)
    else $error("Transmit empty interrupt missing");

  rx_dma_a: assert property (o_rx_dma_req |-> $past(i_rx_full_flag))
    else $error("Receive DMA request without full buffer");

endmodule : spicc_top

//--- verif/spicc_far_side.sv
// Far-side model: bus clock ticks, the chip-select pin and the shifter busy level.
// Assumes the bench requests frames and pin levels; ticks run free like bus clocks.
`timescale 1ns/1ps
module spicc_far_side (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_slow,
  input wire logic i_frame_req,
  input wire logic i_pin_req,
  output logic o_first_bus_tick,
  output logic o_second_bus_tick,
  output logic o_shift_busy,
  output logic o_chip_select_pin
);
  logic [1:0] cnt_a;
  logic [1:0] cnt_b;
  ////////////////////////////////////////////////////////////
  // Unequal tick rates, so a wrong bus clock choice shows in the bit clock period
  always_ff @(posedge i_mclk) begin
    if (i_srst || cnt_a == 2'h2) begin
      cnt_a <= 2'h0;
    end else begin
      cnt_a <= cnt_a + 2'h1;
    end
    cnt_b <= i_srst ? 2'h0 : cnt_b + 2'h1;
    o_first_bus_tick <= (cnt_a == 2'h2);
    o_second_bus_tick <= i_slow ? (cnt_b == 2'h3) : cnt_b[0];
  end
  // Pin idles high through its pull-up
  always_ff @(posedge i_mclk) begin
    o_chip_select_pin <= i_srst | i_pin_req;
    o_shift_busy <= ~i_srst & i_frame_req;
  end
endmodule : spicc_far_side

//--- verif/spi_control_configuration_test.sv
// Self-checking bench for the serial port control block.
// Assumes one wait cycle per register access and one cycle of decode latency.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("unexpected at %0t got %0h exp %0h", $time, got, exp); \
  end \
end
module spi_control_configuration_test;
  localparam logic [7:0] MAIN = spicc_pkg::MAIN_OFS;
  localparam logic [7:0] AUX = spicc_pkg::AUX_OFS;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] i_address = 8'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0000_0000;
  logic [3:0] i_byteenable = 4'hF;
  logic i_audio_mode = 1'b0;
  logic [5:0] flags = 6'h00;
  logic slow = 1'b0;
  logic frame_req = 1'b0;
  logic pin_req = 1'b1;
  logic [31:0] o_readdata;
  logic o_waitrequest, i_first_bus_tick, i_second_bus_tick, i_shift_busy, i_chip_select_pin;
  logic o_one_line_mode, o_tx_active, o_rx_active, o_checksum_enable, o_checksum_next;
  logic o_frame_16, o_lsb_first, o_port_enable, o_master, o_capture_second, o_serial_clk;
  logic o_select_level, o_chip_select_out, o_chip_select_oe, o_select_pulse, o_frame_format;
  logic o_irq, o_tx_dma_req, o_rx_dma_req;
  int error_cnt = 0;
  int compares = 0;
  always #5 i_mclk = ~i_mclk;
  spicc_top u_spicc_top (.i_mclk, .i_srst, .i_address, .i_read, .i_write, .i_writedata,
    .i_byteenable, .o_readdata, .o_waitrequest, .i_audio_mode, .i_first_bus_tick,
    .i_second_bus_tick, .i_shift_busy, .i_chip_select_pin, .i_tx_empty_flag(flags[5]),
    .i_rx_full_flag(flags[4]), .i_checksum_fault_flag(flags[3]),
    .i_config_fault_flag(flags[2]), .i_rx_overrun_flag(flags[1]),
    .i_tx_underrun_flag(flags[0]), .o_one_line_mode, .o_tx_active, .o_rx_active,
    .o_checksum_enable, .o_checksum_next, .o_frame_16, .o_lsb_first, .o_port_enable,
    .o_master, .o_capture_second, .o_serial_clk, .o_select_level, .o_chip_select_out,
    .o_chip_select_oe, .o_select_pulse, .o_frame_format, .o_irq, .o_tx_dma_req,
    .o_rx_dma_req);
  spicc_far_side u_spicc_far_side (.i_mclk, .i_srst, .i_slow(slow), .i_frame_req(frame_req),
    .i_pin_req(pin_req), .o_first_bus_tick(i_first_bus_tick),
    .o_second_bus_tick(i_second_bus_tick), .o_shift_busy(i_shift_busy),
    .o_chip_select_pin(i_chip_select_pin));
  ////////////////////////////////////////////////////////////
  // Holds the request until waitrequest is sampled low; the watchdog ends a hang
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] q);
    i_address <= a;
    i_writedata <= d;
    i_byteenable <= be;
    i_read <= rd;
    i_write <= ~rd;
    @(posedge i_mclk);
    while (o_waitrequest !== 1'b0) begin
      @(posedge i_mclk);
    end
    q = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
    repeat (3) @(posedge i_mclk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, 4'hF, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b1, a, 32'h0000_0000, 4'hF, q);
    `CHK(q, exp)
  endtask : rd_chk
  task automatic t_regs;
    logic [31:0] q;
    `CHK(o_port_enable, 1'b0)
    `CHK(o_select_level, 1'b1)
    rd_chk(MAIN, 32'h0000_0000);
    rd_chk(AUX, 32'h0000_0000);
    rd_chk(spicc_pkg::STATE_OFS, 32'h0000_0003);
    wr(MAIN, 32'hFFFF_FFFF);
    rd_chk(MAIN, 32'h0000_FFFF);
    wr(AUX, 32'hFFFF_FFFF);
    rd_chk(AUX, 32'h0000_00FF);
    bus(1'b0, MAIN, 32'h0000_0000, 4'h2, q);
    rd_chk(MAIN, 32'h0000_00FF);
    wr(8'h10, 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'h0000_0000);
    wr(AUX, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_modes;
    logic [15:0] cfg [4] = '{16'h0040, 16'h0440, 16'h8040, 16'hC040};
    logic [3:0] tx_exp = 4'b1001;
    logic [3:0] rx_exp = 4'b0111;
    for (int i = 0; i < 4; i++) begin
      wr(MAIN, {16'h0000, cfg[i]});
      `CHK(o_one_line_mode, cfg[i][15])
      `CHK(o_tx_active, tx_exp[i])
      `CHK(o_rx_active, rx_exp[i])
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_fields;
    // Checksum word follows the final data word
    wr(MAIN, 32'h0000_38C5);
    `CHK(o_checksum_enable, 1'b1)
    `CHK(o_checksum_next, 1'b1)
    `CHK(o_frame_16, 1'b1)
    `CHK(o_lsb_first, 1'b1)
    `CHK(o_master, 1'b1)
    `CHK(o_capture_second, 1'b1)
    `CHK(o_port_enable, 1'b1)
    `CHK(o_chip_select_out, 1'b0)
    wr(AUX, 32'h0000_0002);
    `CHK(o_checksum_next, 1'b0)
    wr(AUX, 32'h0000_0000);
    wr(MAIN, 32'h0000_1000);
    `CHK(o_checksum_next, 1'b0)
    `CHK(o_frame_16, 1'b0)
    `CHK(o_lsb_first, 1'b0)
    `CHK(o_master, 1'b0)
    `CHK(o_capture_second, 1'b0)
    `CHK(o_chip_select_out, 1'b1)
    `CHK(o_port_enable, 1'b0)
    wr(MAIN, 32'h0000_38C5);
    i_audio_mode <= 1'b1;
    repeat (3) @(posedge i_mclk);
    `CHK(o_port_enable, 1'b0)
    `CHK(o_frame_16, 1'b0)
    rd_chk(MAIN, 32'h0000_38C5);
    i_audio_mode <= 1'b0;
    repeat (3) @(posedge i_mclk);
    `CHK(o_master, 1'b1)
    $display("test fields done");
  endtask : t_fields
  task automatic t_select;
    wr(MAIN, 32'h0000_0200);
    `CHK(o_select_level, 1'b0)
    wr(MAIN, 32'h0000_0300);
    `CHK(o_select_level, 1'b1)
    wr(MAIN, 32'h0000_0000);
    pin_req <= 1'b0;
    repeat (8) @(posedge i_mclk);
    `CHK(o_select_level, 1'b0)
    pin_req <= 1'b1;
    wr(AUX, 32'h0000_001C);
    wr(MAIN, 32'h0000_0280);
    `CHK(o_select_level, 1'b1)
    `CHK(o_lsb_first, 1'b0)
    `CHK(o_frame_format, 1'b1)
    `CHK(o_select_pulse, 1'b1)
    `CHK(o_chip_select_oe, 1'b1)
    wr(AUX, 32'h0000_0000);
    `CHK(o_chip_select_oe, 1'b0)
    `CHK(o_select_pulse, 1'b0)
    `CHK(o_select_level, 1'b0)
    $display("test select done");
  endtask : t_select
  task automatic t_div;
    int n;
    int half;
    logic last;
    for (int c = 0; c < 8; c++) begin
      slow <= (c > 5);
      wr(MAIN, {16'h0000, 10'h001, c[2:0], 3'h4});
      frame_req <= 1'b1;
      half = (c == 7 ? 64 : 1 << c) * (c > 5 ? 4 : 2);
      for (int k = 0; k < 2; k++) begin
        last = o_serial_clk;
        n = 0;
        while (o_serial_clk === last && n < 600) begin
          @(posedge i_mclk);
          n++;
        end
      end
      `CHK(n, half)
      frame_req <= 1'b0;
      repeat (4) @(posedge i_mclk);
      `CHK(o_serial_clk, 1'b0)
    end
    slow <= 1'b0;
    wr(MAIN, 32'h0000_0046);
    `CHK(o_serial_clk, 1'b1)
    wr(MAIN, 32'h0000_0040);
    frame_req <= 1'b1;
    repeat (20) @(posedge i_mclk);
    `CHK(o_serial_clk, 1'b0)
    frame_req <= 1'b0;
    $display("test divider done");
  endtask : t_div
  task automatic t_irq;
    logic [7:0] av [11] = '{8'h80, 8'h40, 8'h40, 8'h20, 8'h20, 8'h20, 8'h20, 8'hC0, 8'h03,
      8'h02, 8'h01};
    logic [5:0] fv [11] = '{6'h20, 6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h0F, 6'h30,
      6'h10, 6'h20};
    logic exp_irq;
    for (int i = 0; i < 11; i++) begin
      flags <= fv[i];
      wr(AUX, {24'h000000, av[i]});
      exp_irq = (av[i][7] & fv[i][5]) | (av[i][6] & fv[i][4]) | (av[i][5] & |fv[i][3:0]);
      `CHK(o_irq, exp_irq)
      `CHK(o_tx_dma_req, av[i][1] & fv[i][5])
      `CHK(o_rx_dma_req, av[i][0] & fv[i][4])
    end
    $display("test interrupt done");
  endtask : t_irq
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge i_mclk);
    i_srst <= 1'b0;
    repeat (4) @(posedge i_mclk);
    t_regs();
    t_modes();
    t_fields();
    t_select();
    t_div();
    t_irq();
    wrap_up();
  end
  // Whole run needs under two thousand cycles; this leaves ample margin
  initial begin
    repeat (30000) @(posedge i_mclk);
    error_cnt++;
    wrap_up();
  end
endmodule : spi_control_configuration_test
